/* File: hdl/imf_formatter.sv */
// Purpose: barcode message formatter for an industrial ethernet client, with
//   client-driven digital outputs and a conveyor speed / input monitor
// Assumes: all inputs synchronous to clk_sys; cfg_* held stable within a frame
// Notes: output words pass through a two-entry buffer
// Summary of operation
// - In ASCII format the header and trailer bytes are removed and only payload goes out, apart from the pad byte that swap puts in front of an odd final byte.
// - In ASCII format with swap on, the two bytes of every 16-bit word leave in exchanged order.
// - In Binary format the digits are turned into a number sent as one 32-bit word.
// - In Binary format any character other than a digit or a leading or trailing space yields zero.
// - Little-endian order puts the least significant byte of the number at the lowest address.
// - Big-endian order puts the most significant byte of the number at the lowest address.
// - The byte order choice acts only in Binary format and has no effect on ASCII data.
// - Output 1, when given to the link with client control on, follows bit 0 of the client output bits.
// - Output 2, when given to the link with client control on, follows bit 1 of the client output bits.
// - In percentage mode a speed deviation above the percent threshold is an error.
// - At the end of each input timeout interval in seconds, pending errors go to the supervisor.
module imf_formatter #(
  parameter int CYC_PER_TICK = imf_pkg::CYC_PER_TICK
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cfg_format,
  input wire logic cfg_ascii_swap,
  input wire logic cfg_byte_order,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_payload,
  input wire logic in_last,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic [7:0] client_output_bits_byte,
  input wire logic [1:0] out_assigned_eip,
  input wire logic [1:0] out_client_ctl_en,
  input wire logic [1:0] out_other_fn,
  output logic [1:0] dig_out,
  input wire logic speed_sample,
  input wire logic [15:0] speed_meas,
  input wire logic [15:0] speed_expect,
  input wire logic cfg_check_mode,
  input wire logic [7:0] cfg_pct_thr,
  input wire logic [15:0] cfg_abs_thr,
  input wire logic monitor_input_err,
  input wire logic [7:0] cfg_input_timeout_s,
  output logic sup_report,
  output logic sup_speed_err,
  output logic sup_input_err
);
  localparam logic [imf_pkg::TICK_CNT_W-1:0] TICK_LAST = imf_pkg::TICK_CNT_W'(CYC_PER_TICK - 1);

  typedef struct packed {
    imf_pkg::imf_state_e st;
    logic [15:0] pair;
    logic [1:0] pr_n;
    logic [31:0] acc;
    logic bad;
    logic dig;
    logic trail;
    logic [31:0] ebuf;
    logic [2:0] en;
    logic [1:0] eidx;
    logic elast;
    logic [1:0] dout;
    logic [imf_pkg::TICK_CNT_W-1:0] tick_cnt;
    logic [7:0] sec_cnt;
    logic err_speed;
    logic err_input;
    logic rep;
    logic rep_speed;
    logic rep_input;
  } imf_core_s;

  imf_core_s q;
  imf_core_s d;
  imf_byte_if bif ();
  logic [8:0] buf_word;
  logic [1:0] dout_n;
  logic load_pair;
  logic load_bin;
  logic stall_pair;
  logic [15:0] pair_c;
  logic [15:0] pair_swap_c;
  logic [1:0] cnt_c;
  logic [31:0] acc_c;
  logic [31:0] acc_swap_c;
  logic bad_c;
  logic [15:0] diff;
  logic [23:0] diff_scaled;
  logic [23:0] pct_limit;
  logic over_pct;
  logic over_abs;
  logic speed_ev;
  logic tick;
  logic expire;

  // client bits steer a pin only while both the assignment and the enable are set
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      assign dout_n[gi] = (out_assigned_eip[gi] && out_client_ctl_en[gi]) ?
                          client_output_bits_byte[gi] : out_other_fn[gi];
    end
  endgenerate

  assign diff = (speed_meas >= speed_expect) ? speed_meas - speed_expect : speed_expect - speed_meas;
  assign diff_scaled = 24'(diff * 24'(imf_pkg::PCT_SCALE));
  assign pct_limit = 24'(speed_expect * cfg_pct_thr);
  assign over_pct = diff_scaled > pct_limit;
  assign over_abs = diff > cfg_abs_thr;
  assign speed_ev = speed_sample && ((cfg_check_mode == imf_pkg::CHK_ABS) ? over_abs : over_pct);
  assign tick = (q.tick_cnt == TICK_LAST);
  // a zero timeout disables reporting
  assign expire = tick && (cfg_input_timeout_s != 8'h00) && (q.sec_cnt + 8'h01 >= cfg_input_timeout_s);
  assign pair_swap_c = {pair_c[7:0], pair_c[15:8]};
  assign acc_swap_c = {acc_c[7:0], acc_c[15:8], acc_c[23:16], acc_c[31:24]};

  assign in_ready = (q.st == imf_pkg::IMF_ST_RUN) && !stall_pair;
  assign dig_out = q.dout;
  assign sup_report = q.rep;
  assign sup_speed_err = q.rep_speed;
  assign sup_input_err = q.rep_input;
  assign out_data = buf_word[7:0];
  assign out_last = buf_word[8];

  always_comb begin
    d = q;
    pair_c = q.pair;
    cnt_c = q.pr_n;
    acc_c = q.acc;
    bad_c = q.bad;
    load_pair = 1'b0;
    load_bin = 1'b0;
    stall_pair = 1'b0;
    bif.valid = 1'b0;
    bif.data = q.ebuf[8 * q.eidx +: 8];
    bif.last = 1'b0;
    unique case (q.st)
      imf_pkg::IMF_ST_RUN: begin
        // a third payload byte waits until the held word has gone out
        stall_pair = (cfg_format == imf_pkg::FMT_ASCII) && in_payload && (q.pr_n == 2'h2);
        if (in_valid && stall_pair) begin
          load_pair = 1'b1;
        end else if (in_valid && (cfg_format == imf_pkg::FMT_ASCII)) begin
          if (in_payload) begin
            if (q.pr_n == 2'h0) begin
              pair_c[7:0] = in_data;
            end else begin
              pair_c[15:8] = in_data;
            end
            cnt_c = q.pr_n + 2'h1;
          end
          // a frame without payload sends nothing
          load_pair = in_last && (cnt_c != 2'h0);
          if (in_last) begin
            d.bad = 1'b0;
          end
        end else if (in_valid) begin
          if (in_payload) begin
            if (in_data >= imf_pkg::CH_0 && in_data <= imf_pkg::CH_9) begin
              if (q.trail) begin
                bad_c = 1'b1;
              end
              acc_c = 32'((q.acc << 3) + (q.acc << 1) + {24'h0, in_data - imf_pkg::CH_0});
              d.dig = 1'b1;
            end else if (in_data == imf_pkg::CH_SP) begin
              d.trail = q.dig;
            end else begin
              bad_c = 1'b1;
            end
          end
          d.acc = acc_c;
          d.bad = bad_c;
          if (in_last) begin
            load_bin = 1'b1;
          end
        end
        d.pair = pair_c;
        d.pr_n = cnt_c;
        if (load_pair) begin
          d.ebuf = {16'h0000, pair_c};
          d.en = {1'b0, cnt_c};
          if (cfg_ascii_swap) begin
            // an odd final byte is paired with a pad byte in front of it
            d.ebuf[15:0] = (cnt_c == 2'h2) ? pair_swap_c : {pair_c[7:0], imf_pkg::PAD_BYTE};
            d.en = imf_pkg::PAIR_BYTES;
          end
          d.elast = !stall_pair;
          d.pair = 16'h0000;
          d.pr_n = 2'h0;
          d.eidx = 2'h0;
          d.st = imf_pkg::IMF_ST_EMIT;
        end
        if (load_bin) begin
          if (bad_c) begin
            d.ebuf = 32'h0000_0000;
          end else if (cfg_byte_order == imf_pkg::ORD_BIG) begin
            d.ebuf = acc_swap_c;
          end else begin
            d.ebuf = acc_c;
          end
          d.en = imf_pkg::BIN_BYTES;
          d.elast = 1'b1;
          d.eidx = 2'h0;
          d.acc = 32'h0000_0000;
          d.bad = 1'b0;
          d.dig = 1'b0;
          d.trail = 1'b0;
          d.st = imf_pkg::IMF_ST_EMIT;
        end
      end
      imf_pkg::IMF_ST_EMIT: begin
        bif.valid = 1'b1;
        bif.last = q.elast && ((3'(q.eidx) + 3'h1) == q.en);
        if (bif.ready) begin
          if ((3'(q.eidx) + 3'h1) == q.en) begin
            d.st = imf_pkg::IMF_ST_RUN;
            d.eidx = 2'h0;
          end else begin
            d.eidx = q.eidx + 2'h1;
          end
        end
      end
    endcase

    d.dout = dout_n;
    d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
    if (expire || cfg_input_timeout_s == 8'h00) begin
      d.sec_cnt = 8'h00;
    end else if (tick) begin
      d.sec_cnt = q.sec_cnt + 8'h01;
    end
    // an event in the reporting cycle stays pending for the next interval
    d.rep = expire;
    d.rep_speed = expire && q.err_speed;
    d.rep_input = expire && q.err_input;
    d.err_speed = (expire ? 1'b0 : q.err_speed) | speed_ev;
    d.err_input = (expire ? 1'b0 : q.err_input) | monitor_input_err;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  imf_byte_buf #(
    .W(imf_pkg::BYTE_W + 1),
    .DEPTH(imf_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .up(bif.dst),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_word(buf_word)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_drop_framing:
    assert property ((q.st == imf_pkg::IMF_ST_RUN) && in_valid && in_ready && !in_payload && !in_last &&
                     (cfg_format == imf_pkg::FMT_ASCII) |=> (q.pr_n == $past(q.pr_n)) && (q.st == imf_pkg::IMF_ST_RUN))
    else $error("framing byte was kept in ascii format");
  a_ascii_swap:
    assert property (load_pair && cfg_ascii_swap && (cnt_c == 2'h2) |=>
                     (q.ebuf[15:0] == $past(pair_swap_c)) && (q.en == imf_pkg::PAIR_BYTES))
    else $error("ascii word not byte swapped");
  a_bin_word:
    assert property (load_bin |=> (q.st == imf_pkg::IMF_ST_EMIT) && (q.en == imf_pkg::BIN_BYTES) && q.elast
                     ##[1:40] (bif.valid && bif.ready && bif.last))
    else $error("binary value not sent as four bytes");
  a_bad_zero:
    assert property (load_bin && bad_c |=> q.ebuf == 32'h0000_0000)
    else $error("non numeric message did not give zero");
  a_little_end:
    assert property (load_bin && !bad_c && (cfg_byte_order == imf_pkg::ORD_LITTLE) |=> q.ebuf == $past(acc_c))
    else $error("little endian order wrong");
  a_big_end:
    assert property (load_bin && !bad_c && (cfg_byte_order == imf_pkg::ORD_BIG) |=> q.ebuf == $past(acc_swap_c))
    else $error("big endian order wrong");
  a_ascii_order:
    assert property (load_pair && !cfg_ascii_swap |=> q.ebuf[15:0] == $past(pair_c))
    else $error("byte order choice changed ascii data");
  a_pin_one:
    assert property (out_assigned_eip[0] && out_client_ctl_en[0] |=> dig_out[0] == $past(client_output_bits_byte[0]))
    else $error("output 1 not following client bit 0");
  a_pin_two:
    assert property (out_assigned_eip[1] && out_client_ctl_en[1] |=> dig_out[1] == $past(client_output_bits_byte[1]))
    else $error("output 2 not following client bit 1");
  a_pin_other:
    assert property (!(out_assigned_eip[0] && out_client_ctl_en[0]) |=> dig_out[0] == $past(out_other_fn[0]))
    else $error("output 1 left its other function");
  a_pct_error:
    assert property (speed_sample && (cfg_check_mode == imf_pkg::CHK_PCT) && over_pct |=> q.err_speed)
    else $error("percent speed error not flagged");
  a_abs_error:
    assert property (speed_sample && (cfg_check_mode == imf_pkg::CHK_ABS) && over_abs |=> q.err_speed)
    else $error("absolute speed error not flagged");
  a_timeout_report:
    assert property (expire |=> sup_report && (sup_speed_err == $past(q.err_speed)) ##1 !sup_report)
    else $error("timeout report wrong");
  a_no_early_report:
    assert property (!expire |=> !sup_report)
    else $error("report outside timeout");

  c_bin_frame: cover property (load_bin ##1 (q.st == imf_pkg::IMF_ST_EMIT) [*4]);
  c_swap_pair: cover property (load_pair && cfg_ascii_swap && (cnt_c == 2'h1));
  c_stall: cover property (bif.valid && !bif.ready);
  c_report: cover property (expire && q.err_speed);
endmodule // imf_formatter

/* File: hdl/imf_pkg.sv */
// Purpose: shared constants for the industrial message formatter
// Assumes: 200 MHz system clock
// Notes: offsets of time are expressed as cycle counts derived here
package imf_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_S = 1;
  localparam int CYC_PER_TICK = CLK_HZ * TICK_S;
  localparam int TICK_CNT_W = 28;
  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam int PCT_SCALE = 100;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic FMT_ASCII = 1'b0;
  localparam logic FMT_BINARY = 1'b1;
  localparam logic ORD_LITTLE = 1'b0;
  localparam logic ORD_BIG = 1'b1;
  localparam logic CHK_PCT = 1'b0;
  localparam logic CHK_ABS = 1'b1;
  localparam logic [2:0] BIN_BYTES = 3'h4;
  localparam logic [2:0] PAIR_BYTES = 3'h2;
  typedef enum logic [0:0] {IMF_ST_RUN, IMF_ST_EMIT} imf_state_e;
endpackage

/* File: hdl/imf_byte_if.sv */
// Purpose: byte stream with end marker between formatter core and its buffer
// Assumes: valid/ready handshake, transfer when both high on clk_sys edge
// Notes: data and last must hold while valid is high and ready low
interface imf_byte_if;
  logic valid;
  logic ready;
  logic [imf_pkg::BYTE_W-1:0] data;
  logic last;
  modport src (output valid, output data, output last, input ready);
  modport dst (input valid, input data, input last, output ready);
endinterface

/* File: hdl/imf_byte_buf.sv */
// Purpose: small ring buffer so a stalled receiver loses no word
// Assumes: DEPTH of at least 2
// Notes: ready toward the source drops only when every entry is full
module imf_byte_buf #(
  parameter int W = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  imf_byte_if.dst up,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } imf_buf_s;

  imf_buf_s q;
  imf_buf_s d;
  logic wr_en;
  logic rd_en;

  assign up.ready = (q.cnt != FULL_CNT);
  assign out_valid = (q.cnt != '0);
  assign out_word = q.mem[q.rd];

  always_comb begin
    d = q;
    wr_en = up.valid && up.ready;
    rd_en = out_valid && out_ready;
    if (wr_en) begin
      d.mem[q.wr] = W'({up.last, up.data});
      d.wr = (q.wr == LAST_PTR) ? '0 : q.wr + 1'b1;
    end
    if (rd_en) begin
      d.rd = (q.rd == LAST_PTR) ? '0 : q.rd + 1'b1;
    end
    if (wr_en && !rd_en) begin
      d.cnt = q.cnt + 1'b1;
    end else if (rd_en && !wr_en) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // imf_byte_buf

/* File: verification/imf_client_model.sv */
// Purpose: receiving side of the formatted byte stream, standing in for the link client
// Assumes: one clock; a byte is taken on a rising edge with out_valid and out_ready high
// Notes: stall makes ready toggle every cycle, so the two-entry buffer fills and backs up
module imf_client_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic stall,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx_q[$];

  // plain always: the bench empties the queue between messages
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      // a slow client still never drops a byte that it has acknowledged
      out_ready <= stall ? ~out_ready : 1'b1;
      if (out_valid && out_ready) begin
        rx_q.push_back({out_last, out_data});
      end
    end
  end
endmodule // imf_client_model

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the message formatter, pin mapping and monitor
// Assumes: 200 MHz clock, second tick shortened to 10 cycles
// Notes: expected bytes are written out by hand from the format rules
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, cfg_format, cfg_ascii_swap, cfg_byte_order, in_valid, in_ready, in_payload, in_last;
  logic out_valid, out_ready, out_last, speed_sample, cfg_check_mode, monitor_input_err, sup_report;
  logic sup_speed_err, sup_input_err, stall;
  logic [7:0] in_data, out_data, client_output_bits_byte, cfg_pct_thr, cfg_input_timeout_s;
  logic [1:0] out_assigned_eip, out_client_ctl_en, out_other_fn, dig_out;
  logic [15:0] speed_meas, speed_expect, cfg_abs_thr;
  int bad_count, checked, gap;

  imf_formatter #(.CYC_PER_TICK(10)) u_imf_formatter (.clk_sys, .rst, .cfg_format, .cfg_ascii_swap,
    .cfg_byte_order, .in_valid, .in_ready, .in_data, .in_payload, .in_last, .out_valid, .out_ready,
    .out_data, .out_last, .client_output_bits_byte, .out_assigned_eip, .out_client_ctl_en, .out_other_fn,
    .dig_out, .speed_sample, .speed_meas, .speed_expect, .cfg_check_mode, .cfg_pct_thr, .cfg_abs_thr,
    .monitor_input_err, .cfg_input_timeout_s, .sup_report, .sup_speed_err, .sup_input_err);
  imf_client_model u_imf_client_model (.clk_sys, .rst, .out_valid, .out_data, .out_last, .stall, .out_ready);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // holds the byte up until the core's ready is seen high at an edge
  task automatic send_byte(input logic [7:0] d, input logic p, input logic l);
    int n;
    n = 0;
    in_valid <= 1'b1;
    in_data <= d;
    in_payload <= p;
    in_last <= l;
    @(posedge clk_sys);
    while (in_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 100) chk(9'h0, 9'h1, "input stalled");
  endtask

  // header and trailer are framing bytes that must never reach the client
  task automatic run_msg(input string s, input logic [7:0] e[$]);
    int n;
    u_imf_client_model.rx_q.delete();
    send_byte(8'h02, 1'b0, 1'b0);
    for (int i = 0; i < s.len(); i++) send_byte(s[i], 1'b1, 1'b0);
    send_byte(8'h03, 1'b0, 1'b1);
    in_valid <= 1'b0;
    n = 0;
    while (u_imf_client_model.rx_q.size() < e.size() && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (8) @(posedge clk_sys);
    chk(9'(u_imf_client_model.rx_q.size()), 9'(e.size()), "byte count");
    for (int i = 0; i < e.size() && i < u_imf_client_model.rx_q.size(); i++) begin
      chk(u_imf_client_model.rx_q[i], {i == e.size() - 1, e[i]}, "output byte");
    end
  endtask

  task automatic wait_rep();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (sup_report !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 200) chk(9'h0, 9'h1, "no supervision report");
  endtask

  task automatic spd(input logic mode, input logic [15:0] meas, input logic ierr, input logic es, input logic ei);
    wait_rep();
    cfg_check_mode <= mode;
    speed_meas <= meas;
    speed_sample <= 1'b1;
    monitor_input_err <= ierr;
    @(posedge clk_sys);
    speed_sample <= 1'b0;
    monitor_input_err <= 1'b0;
    wait_rep();
    chk({7'h0, sup_speed_err, sup_input_err}, {7'h0, es, ei}, "monitor flags");
  endtask

  initial begin
    rst = 1'b1;
    {cfg_format, cfg_ascii_swap, cfg_byte_order, in_valid, in_payload, in_last, stall} = '0;
    {speed_sample, cfg_check_mode, monitor_input_err} = '0;
    in_data = 8'h00;
    client_output_bits_byte = 8'h00;
    out_assigned_eip = 2'h0;
    out_client_ctl_en = 2'h0;
    out_other_fn = 2'h0;
    speed_meas = 16'h03e8;
    speed_expect = 16'h03e8;
    cfg_pct_thr = 8'h05;
    cfg_abs_thr = 16'h0014;
    cfg_input_timeout_s = 8'h01;
    bad_count = 0;
    checked = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    run_msg("ABC", '{8'h41, 8'h42, 8'h43});
    cfg_ascii_swap <= 1'b1;
    cfg_byte_order <= 1'b1;
    run_msg("ABC", '{8'h42, 8'h41, 8'h00, 8'h43});
    cfg_format <= 1'b1;
    cfg_byte_order <= 1'b0;
    run_msg(" 12 ", '{8'h0c, 8'h00, 8'h00, 8'h00});
    stall <= 1'b1;
    cfg_byte_order <= 1'b1;
    run_msg("305419896", '{8'h12, 8'h34, 8'h56, 8'h78});
    cfg_byte_order <= 1'b0;
    run_msg("305419896", '{8'h78, 8'h56, 8'h34, 8'h12});
    stall <= 1'b0;
    run_msg("1a2", '{8'h00, 8'h00, 8'h00, 8'h00});
    run_msg("1 2", '{8'h00, 8'h00, 8'h00, 8'h00});
    // each output alone follows its client bit only when assigned and enabled
    for (int k = 0; k < 32; k++) begin
      out_assigned_eip <= 2'(k);
      out_client_ctl_en <= 2'(k >> 2);
      client_output_bits_byte <= k[4] ? 8'hfe : 8'h01;
      out_other_fn <= k[4] ? 2'h1 : 2'h2;
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < 2; i++) begin
        chk({8'h0, dig_out[i]}, {8'h0, (k[i] && k[i + 2]) ? (k[4] ? i == 1 : i == 0) : (k[4] ? i == 0 : i == 1)},
          "digital output");
      end
    end
    spd(1'b0, 16'h041a, 1'b0, 1'b0, 1'b0);
    spd(1'b0, 16'h041b, 1'b0, 1'b1, 1'b0);
    spd(1'b1, 16'h03fc, 1'b0, 1'b0, 1'b0);
    spd(1'b1, 16'h03d3, 1'b0, 1'b1, 1'b0);
    spd(1'b1, 16'h03e8, 1'b1, 1'b0, 1'b1);
    spd(1'b1, 16'h03e8, 1'b0, 1'b0, 1'b0);
    // three seconds of ten cycles each between two reports
    cfg_input_timeout_s <= 8'h03;
    wait_rep();
    gap = 0;
    do begin
      @(posedge clk_sys);
      gap++;
    end while (sup_report !== 1'b1 && gap < 200);
    chk(9'(gap), 9'h01e, "report interval");
    // a zero timeout must keep the supervisor quiet
    cfg_input_timeout_s <= 8'h00;
    gap = 0;
    repeat (40) begin
      @(posedge clk_sys);
      if (sup_report !== 1'b0) begin
        gap++;
      end
    end
    chk(9'(gap), 9'h000, "report while disabled");
    close_out();
  end

  // the whole sequence needs a few hundred cycles; twenty thousand means a hang
  initial begin
    #100us;
    bad_count++;
    close_out();
  end
endmodule // tb_top
